// file: sim/fspc_flash_model.sv
// Behavioural flash array on the far side of the controller
`timescale 1ns/1ps
module fspc_flash_model (
  // Clock
  input wire logic core_clk,
  // Array strobes and read data
  input wire fspc_pkg::fspc_flash_req_type flash_req,
  output logic [fspc_pkg::WORD_W-1:0] flash_rdata
);
  logic [13:0] mem_r [0:2047] = '{default: 14'h3FFF};
  logic [13:0] cfg_r [0:15] = '{default: 14'h3FFF};
  logic [13:0] last_r = 14'h0000;
  logic valid_r = 1'h0;
  wire [10:0] idx = flash_req.addr[10:0];
  // Outside the read slot the line shows no stale word
  assign flash_rdata = valid_r ? last_r : ~last_r;
  always @(posedge core_clk) begin
    valid_r <= flash_req.rd;
    if (flash_req.rd) last_r <= flash_req.cfg ? cfg_r[idx[3:0]] : mem_r[idx];
    if (flash_req.erase) for (int j = 0; j < 16; j++) mem_r[{idx[10:4], 4'(j)}] <= 14'h3FFF;
    if (flash_req.wr && flash_req.cfg) cfg_r[idx[3:0]] <= cfg_r[idx[3:0]] & flash_req.wdata;
    if (flash_req.wr && !flash_req.cfg) mem_r[idx] <= mem_r[idx] & flash_req.wdata;
    if (flash_req.bulk) begin
      for (int j = 0; j < 2048; j++) mem_r[j] <= 14'h3FFF;
      for (int j = 0; j < 16; j++) cfg_r[j] <= 14'h3FFF;
    end
  end
endmodule

// file: sim/tb_top.sv
// Testbench for the flash self-program controller
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] A_LL = fspc_pkg::OFS_LOC_LOW;
  localparam logic [7:0] A_LH = fspc_pkg::OFS_LOC_HIGH;
  localparam logic [7:0] A_WL = fspc_pkg::OFS_WORD_LOW;
  localparam logic [7:0] A_WH = fspc_pkg::OFS_WORD_HIGH;
  localparam logic [7:0] A_CT = fspc_pkg::OFS_CONTROL;
  localparam logic [7:0] A_KY = fspc_pkg::OFS_KEY;
  localparam logic [31:0] C_RD = 32'h1 << fspc_pkg::CB_RD;
  localparam logic [31:0] C_WR = 32'h1 << fspc_pkg::CB_WR;
  localparam logic [31:0] C_PM = 32'h1 << fspc_pkg::CB_PERMIT;
  localparam logic [31:0] C_FT = 32'h1 << fspc_pkg::CB_FAULT;
  localparam logic [31:0] C_ER = 32'h1 << fspc_pkg::CB_ERASE;
  localparam logic [31:0] C_LT = 32'h1 << fspc_pkg::CB_LATCH;
  localparam logic [31:0] C_CF = 32'h1 << fspc_pkg::CB_CONFIG_SPACE_SELECT;
  localparam int PROG_T = 20;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic power_on_rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cfg_readout_lock = 1'h0;
  logic [1:0] cfg_self_program_lock = fspc_pkg::WP_NONE;
  fspc_pkg::fspc_ext_req_type ext_req = '0;
  logic ext_ready;
  logic ext_done;
  logic ext_denied;
  logic [13:0] ext_rdata;
  fspc_pkg::fspc_flash_req_type flash_req;
  logic [13:0] flash_rdata;
  logic core_stall;
  int stall_cnt = 0;
  int err_total = 0;
  int compares = 0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (core_stall === 1'h1) stall_cnt <= stall_cnt + 1;
  // Short program time keeps the run brief
  fspc_ctrl #(.PROG_CYCLES(PROG_T)) i_fspc_ctrl (.core_clk(core_clk), .reset(reset),
    .power_on_rst(power_on_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_readout_lock(cfg_readout_lock), .cfg_self_program_lock(cfg_self_program_lock),
    .ext_req(ext_req), .ext_ready(ext_ready), .ext_done(ext_done),
    .ext_denied(ext_denied), .ext_rdata(ext_rdata), .flash_req(flash_req),
    .flash_rdata(flash_rdata), .core_stall(core_stall));
  fspc_flash_model i_fspc_flash_model (.core_clk(core_clk), .flash_req(flash_req),
    .flash_rdata(flash_rdata));
  task automatic complete_run();
    $display("Mismatches %0d in %0d compares", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    // Timed operations hold the answer off; only the watchdog ends a wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'h0, a, 32'h0, q, e);
    chk(q, exp);
  endtask
  task automatic loc(input logic [14:0] a);
    wr(A_LL, {24'h0, a[7:0]});
    wr(A_LH, {25'h0, a[14:8]});
  endtask
  task automatic wword(input logic [13:0] d);
    wr(A_WL, {24'h0, d[7:0]});
    wr(A_WH, {26'h0, d[13:8]});
  endtask
  task automatic trig(input logic [31:0] c);
    wr(A_KY, {24'h0, fspc_pkg::KEY_FIRST});
    wr(A_KY, {24'h0, fspc_pkg::KEY_SECOND});
    wr(A_CT, c);
  endtask
  task automatic rdw(input logic [14:0] a, input logic [13:0] exp);
    rdx(a, C_RD, exp);
  endtask
  task automatic rdx(input logic [14:0] a, input logic [31:0] c, input logic [13:0] exp);
    loc(a);
    wr(A_CT, c);
    rdc(A_WL, {24'h0, exp[7:0]});
    rdc(A_WH, {26'h0, exp[13:8]});
  endtask
  task automatic ext(input logic [1:0] cmd, input logic [14:0] a, input logic [13:0] d,
    input logic deny, input logic [13:0] exp);
    @(posedge core_clk);
    ext_req <= '{1'h1, cmd, a, d};
    do begin
      @(posedge core_clk);
    end while (ext_ready !== 1'h1);
    ext_req.req <= 1'h0;
    @(posedge core_clk);
    chk({31'h0, ext_done}, 32'h1);
    chk({31'h0, ext_denied}, {31'h0, deny});
    @(posedge core_clk);
    if (cmd == fspc_pkg::EXT_READ && !deny) chk({18'h0, ext_rdata}, {18'h0, exp});
  endtask
  function automatic logic [13:0] pat(input int i);
    return {4'(i), 10'h2B5};
  endfunction
  initial begin
    logic [31:0] q;
    logic e;
    int s;
    repeat (8) @(posedge core_clk);
    reset <= 1'h0;
    rdc(A_CT, 32'h0);
    wr(A_KY, 32'h55);
    rdc(A_KY, 32'h0);
    apb(1'h0, 8'h18, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    loc(15'h7ABC);
    rdc(A_LL, 32'hBC);
    rdc(A_LH, 32'h7A);
    wword(14'h3FFF);
    rdc(A_WH, 32'h3F);
    rdw(15'h0120, 14'h3FFF);
    rdc(A_CT, 32'h0);
    ext(fspc_pkg::EXT_READ, 15'h0120, 14'h0, 1'h1, 14'h0);
    ext(fspc_pkg::EXT_WRITE, 15'h0120, 14'h0000, 1'h1, 14'h0);
    for (int i = 0; i < 16; i++) begin
      loc(15'(15'h0120 + i));
      wword(pat(i));
      trig(C_WR | C_PM | C_LT);
    end
    loc(15'h0120);
    s = stall_cnt;
    wr(A_CT, C_WR | C_PM);
    wr(A_KY, 32'h55);
    wr(A_KY, 32'hAA);
    wr(A_CT, C_WR);
    rdw(15'h0120, 14'h3FFF);
    chk(stall_cnt - s, 32'h0);
    loc(15'h0120);
    trig(C_WR | C_PM);
    for (int i = 0; i < 16; i++) rdw(15'(15'h0120 + i), pat(i));
    loc(15'h0000);
    rdc(A_WH, {26'h0, 6'(pat(15) >> 8)});
    loc(15'h0300);
    trig(C_WR | C_PM | C_ER);
    repeat (4) @(posedge core_clk);
    reset <= 1'h1;
    power_on_rst <= 1'h0;
    cfg_readout_lock <= 1'h1;
    cfg_self_program_lock <= fspc_pkg::WP_QUARTER;
    repeat (2) @(posedge core_clk);
    reset <= 1'h0;
    rdc(A_CT, C_FT);
    ext(fspc_pkg::EXT_WRITE, 15'h0600, 14'h1234, 1'h0, 14'h0);
    ext(fspc_pkg::EXT_READ, 15'h0600, 14'h0, 1'h0, 14'h1234);
    s = stall_cnt;
    loc(15'h0605);
    trig(C_WR | C_PM | C_ER);
    rdw(15'h0600, 14'h3FFF);
    chk(stall_cnt - s, 32'(1 + PROG_T));
    loc(15'h0125);
    trig(C_WR | C_PM | C_ER);
    rdw(15'h0120, pat(0));
    ext(fspc_pkg::EXT_READ, 15'h012F, 14'h0, 1'h0, pat(15));
    loc(15'h0000);
    trig(C_WR | C_PM | C_CF);
    rdx(15'h0003, C_RD | C_CF, pat(3));
    ext(fspc_pkg::EXT_BULK, 15'h0000, 14'h0, 1'h0, 14'h0);
    ext(fspc_pkg::EXT_READ, 15'h0120, 14'h0, 1'h0, 14'h3FFF);
    rdx(15'h0003, C_RD | C_CF, 14'h3FFF);
    complete_run();
  end
  // Cuts a hang short well past the expected run length
  initial begin
    #500us;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule

// file: src/fspc_ctrl.sv
// Flash self-program controller with bus registers and programmer port
`timescale 1ns/1ps
module fspc_ctrl #(
  parameter int PROG_CYCLES = fspc_pkg::PROG_TIME_US * fspc_pkg::CLK_MHZ
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic power_on_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration words
  input wire logic cfg_readout_lock,
  input wire logic [1:0] cfg_self_program_lock,
  // External programmer
  input wire fspc_pkg::fspc_ext_req_type ext_req,
  output logic ext_ready,
  output logic ext_done,
  output logic ext_denied,
  output logic [fspc_pkg::WORD_W-1:0] ext_rdata,
  // Flash array
  output fspc_pkg::fspc_flash_req_type flash_req,
  input wire logic [fspc_pkg::WORD_W-1:0] flash_rdata,
  // Core stall
  output logic core_stall
);
  localparam int TIMER_W_L = fspc_pkg::TIMER_W;
  localparam logic [TIMER_W_L-1:0] TIMER_LOAD = TIMER_W_L'(PROG_CYCLES - 1);
  fspc_pkg::fspc_state_type state_r;
  logic [7:0] loc_low_r;
  logic [6:0] loc_high_r;
  logic [7:0] word_low_r;
  logic [5:0] word_high_r;
  logic rd_r;
  logic wr_r;
  logic store_permit_r;
  logic store_fault_flag_r;
  logic erase_sel_r;
  logic latch_only_r;
  logic config_space_select_r;
  logic [1:0] key_st_r;
  logic auth_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic code_readout_lock_r;
  logic [1:0] self_program_lock_r;
  logic cfg_load_r;
  logic [TIMER_W_L-1:0] timer_r;
  logic [fspc_pkg::IDX_W:0] strm_r;
  logic ext_pend_r;
  logic ext_done_r;
  logic ext_denied_r;
  logic [fspc_pkg::WORD_W-1:0] ext_rdata_r;
  logic [fspc_pkg::WORD_W-1:0] latch_rdata;

  wire [fspc_pkg::ADDR_W-1:0] loc = {loc_high_r, loc_low_r};
  wire [fspc_pkg::WORD_W-1:0] word = {word_high_r, word_low_r};
  wire [fspc_pkg::ADDR_W-1:0] row_base = {loc[14:4], 4'h0};

  // Bus decode
  wire sel_loc_low = paddr == fspc_pkg::OFS_LOC_LOW;
  wire sel_loc_high = paddr == fspc_pkg::OFS_LOC_HIGH;
  wire sel_word_low = paddr == fspc_pkg::OFS_WORD_LOW;
  wire sel_word_high = paddr == fspc_pkg::OFS_WORD_HIGH;
  wire sel_control = paddr == fspc_pkg::OFS_CONTROL;
  wire sel_key = paddr == fspc_pkg::OFS_KEY;
  wire sel_hit = sel_loc_low | sel_loc_high | sel_word_low | sel_word_high |
                 sel_control | sel_key;
  wire idle = state_r == fspc_pkg::ST_IDLE;
  wire access = psel & penable;
  wire xfer_done = access & pready_r;
  // No answer while a set trigger waits, so a write never meets its clear
  wire answer_ok = access & ~pready_r & idle & ~rd_r & ~wr_r;
  wire wr_fire = xfer_done & pwrite & sel_hit;
  wire ctrl_wr = wr_fire & sel_control;
  wire key_wr = wr_fire & sel_key;
  wire wr_busy = (state_r == fspc_pkg::ST_ERASE) | (state_r == fspc_pkg::ST_STREAM) |
                 (state_r == fspc_pkg::ST_TIME);

  wire [7:0] ctrl_view = {~idle, config_space_select_r, latch_only_r, erase_sel_r,
                          store_fault_flag_r, store_permit_r, wr_r, rd_r};

  wire [31:0] rd_mux = sel_loc_low ? {24'h000000, loc_low_r} :
                       sel_loc_high ? {25'h0000000, loc_high_r} :
                       sel_word_low ? {24'h000000, word_low_r} :
                       sel_word_high ? {26'h0000000, word_high_r} :
                       sel_control ? {24'h000000, ctrl_view} : 32'h00000000;

  function automatic logic wp_hit(input logic [1:0] wp, input logic [14:0] a,
                                  input logic config_space_select);
    logic hit;
    hit = 1'b0;
    if (!config_space_select) begin
      unique case (wp)
        fspc_pkg::WP_NONE: hit = 1'b0;
        fspc_pkg::WP_QUARTER: hit = a < fspc_pkg::WP_LIM_QUARTER;
        fspc_pkg::WP_HALF: hit = a < fspc_pkg::WP_LIM_HALF;
        default: hit = a < fspc_pkg::WP_LIM_ALL;
      endcase
    end
    return hit;
  endfunction

  wire target_locked = wp_hit(self_program_lock_r, row_base, config_space_select_r);
  wire ext_go = ext_req.req & ext_ready;
  wire ext_blocked = ~code_readout_lock_r & (ext_req.cmd != fspc_pkg::EXT_BULK);
  wire ext_rd = ext_go & ~ext_blocked & (ext_req.cmd == fspc_pkg::EXT_READ);
  wire ext_wr = ext_go & ~ext_blocked & (ext_req.cmd == fspc_pkg::EXT_WRITE);
  wire ext_bulk = ext_go & (ext_req.cmd == fspc_pkg::EXT_BULK);

  // array open to core and programmer
  wire strm_emit = (state_r == fspc_pkg::ST_STREAM) & (strm_r != '0);
  wire [fspc_pkg::IDX_W-1:0] strm_idx = fspc_pkg::IDX_W'(strm_r - 1'b1);
  assign flash_req.rd = (state_r == fspc_pkg::ST_RD) | ext_rd;
  assign flash_req.wr = strm_emit | ext_wr;
  assign flash_req.erase = state_r == fspc_pkg::ST_ERASE;
  assign flash_req.bulk = ext_bulk;
  assign flash_req.cfg = idle ? 1'b0 : config_space_select_r;
  assign flash_req.addr = ~idle ? (strm_emit ? (row_base | {11'h000, strm_idx}) :
                          (flash_req.erase ? row_base : loc)) : ext_req.addr;
  assign flash_req.wdata = strm_emit ? latch_rdata : ext_req.wdata;

  assign core_stall = wr_busy;
  assign ext_ready = idle & ~rd_r & ~wr_r & ~cfg_load_r & ~ext_pend_r;
  assign ext_done = ext_done_r;
  assign ext_denied = ext_denied_r;
  assign ext_rdata = ext_rdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // latches fed only through the word pair
  fspc_latch_mem i_fspc_latch_mem (
    .core_clk(core_clk),
    .we(state_r == fspc_pkg::ST_LOAD),
    .waddr(loc_low_r[3:0]),
    .wdata(word),
    .raddr(strm_r[3:0]),
    .rdata(latch_rdata)
  );

  // Answer one cycle into the access phase; stalls hold the core off
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= answer_ok;
      pslverr_r <= answer_ok & ~sel_hit;
      prdata_r <= rd_mux;
    end
  end

  // fault survives a reset that cut a write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      store_fault_flag_r <= power_on_rst ? 1'b0 : (store_fault_flag_r | wr_busy);
    end else if (ctrl_wr) begin
      store_fault_flag_r <= pwdata[fspc_pkg::CB_FAULT];
    end
  end

  // Address and word pair
  always_ff @(posedge core_clk) begin
    if (reset) begin
      loc_low_r <= 8'h00;
      loc_high_r <= 7'h00;
      word_low_r <= 8'h00;
      word_high_r <= 6'h00;
    end else begin
      if (wr_fire & sel_loc_low) loc_low_r <= pwdata[7:0];
      if (wr_fire & sel_loc_high) loc_high_r <= pwdata[6:0];
      // pair holds until read or write
      if (state_r == fspc_pkg::ST_RDCAP) begin
        {word_high_r, word_low_r} <= flash_rdata;
      end else begin
        if (wr_fire & sel_word_low) word_low_r <= pwdata[7:0];
        if (wr_fire & sel_word_high) word_high_r <= pwdata[5:0];
      end
    end
  end

  // key must directly precede the trigger
  always_ff @(posedge core_clk) begin
    if (reset) begin
      key_st_r <= 2'h0;
    end else if (key_wr) begin
      key_st_r <= (pwdata[7:0] == fspc_pkg::KEY_FIRST) ? 2'h1 :
                  ((pwdata[7:0] == fspc_pkg::KEY_SECOND) && (key_st_r == 2'h1)) ? 2'h2 : 2'h0;
    end else if (wr_fire) begin
      key_st_r <= 2'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      store_permit_r <= 1'b0;
      erase_sel_r <= 1'b0;
      latch_only_r <= 1'b0;
      config_space_select_r <= 1'b0;
      auth_r <= 1'b0;
    end else if (ctrl_wr) begin
      rd_r <= rd_r | pwdata[fspc_pkg::CB_RD];
      wr_r <= wr_r | pwdata[fspc_pkg::CB_WR];
      store_permit_r <= pwdata[fspc_pkg::CB_PERMIT];
      erase_sel_r <= pwdata[fspc_pkg::CB_ERASE];
      latch_only_r <= pwdata[fspc_pkg::CB_LATCH];
      config_space_select_r <= pwdata[fspc_pkg::CB_CONFIG_SPACE_SELECT];
      auth_r <= (key_st_r == 2'h2) & pwdata[fspc_pkg::CB_PERMIT];
    end else begin
      if (state_r == fspc_pkg::ST_RDCAP) rd_r <= 1'b0;
      if (state_r == fspc_pkg::ST_FINISH) wr_r <= 1'b0;
    end
  end

  // only bulk erase lifts the readout lock
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_load_r <= 1'b1;
      code_readout_lock_r <= 1'b0;
      self_program_lock_r <= 2'h0;
    end else if (ext_bulk) begin
      cfg_load_r <= 1'b0;
      code_readout_lock_r <= 1'b1;
      self_program_lock_r <= fspc_pkg::WP_NONE;
    end else if (cfg_load_r) begin
      cfg_load_r <= 1'b0;
      code_readout_lock_r <= cfg_readout_lock;
      self_program_lock_r <= cfg_self_program_lock;
    end
  end

  // Programmer answers one cycle after its request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ext_pend_r <= 1'b0;
      ext_done_r <= 1'b0;
      ext_denied_r <= 1'b0;
      ext_rdata_r <= '0;
    end else begin
      ext_pend_r <= ext_rd;
      ext_done_r <= ext_go;
      ext_denied_r <= ext_go & ext_blocked;
      if (ext_pend_r) ext_rdata_r <= flash_rdata;
    end
  end

  // Sequencer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= fspc_pkg::ST_IDLE;
      timer_r <= '0;
      strm_r <= '0;
    end else begin
      unique case (state_r)
        fspc_pkg::ST_IDLE: begin
          strm_r <= '0;
          if (wr_r) begin
            // locked target never reaches the array
            state_r <= !auth_r ? fspc_pkg::ST_FINISH :
                       latch_only_r ? fspc_pkg::ST_LOAD :
                       target_locked ? fspc_pkg::ST_FINISH :
                       erase_sel_r ? fspc_pkg::ST_ERASE : fspc_pkg::ST_STREAM;
          end else if (rd_r) begin
            state_r <= fspc_pkg::ST_RD;
          end
        end
        // read in second cycle, data next
        fspc_pkg::ST_RD: state_r <= fspc_pkg::ST_RDCAP;
        fspc_pkg::ST_RDCAP: state_r <= fspc_pkg::ST_IDLE;
        fspc_pkg::ST_LOAD: state_r <= fspc_pkg::ST_FINISH;
        fspc_pkg::ST_ERASE: begin
          timer_r <= TIMER_LOAD;
          state_r <= fspc_pkg::ST_TIME;
        end
        // program writes only, no implied erase
        fspc_pkg::ST_STREAM: begin
          strm_r <= strm_r + 1'b1;
          if (strm_r == (fspc_pkg::IDX_W+1)'(fspc_pkg::ROW_WORDS)) begin
            timer_r <= TIMER_LOAD;
            state_r <= fspc_pkg::ST_TIME;
          end
        end
        fspc_pkg::ST_TIME: begin
          timer_r <= timer_r - 1'b1;
          if (timer_r == '0) state_r <= fspc_pkg::ST_FINISH;
        end
        fspc_pkg::ST_FINISH: state_r <= fspc_pkg::ST_IDLE;
      endcase
    end
  end

  rd_trig_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r == fspc_pkg::ST_RDCAP |=> !rd_r)
    else $error("read trigger not cleared");
  refuse_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    idle && wr_r && !auth_r |=> state_r == fspc_pkg::ST_FINISH ##1 !wr_r && idle)
    else $error("unauthorised trigger not refused");
  permit_needed_a: assert property (@(posedge core_clk) disable iff (reset)
    flash_req.erase || strm_emit || state_r == fspc_pkg::ST_LOAD |-> store_permit_r)
    else $error("write without permit");
  key_reads_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    xfer_done && !pwrite && sel_key |-> prdata == 32'h00000000)
    else $error("key register read nonzero");
  ext_lock_a: assert property (@(posedge core_clk) disable iff (reset)
    ext_go && !code_readout_lock_r && ext_req.cmd != fspc_pkg::EXT_BULK
    |-> !flash_req.rd && !flash_req.wr ##1 ext_denied)
    else $error("locked programmer access passed");
  wp_guard_a: assert property (@(posedge core_clk) disable iff (reset)
    flash_req.erase || strm_emit |-> !target_locked)
    else $error("locked row modified");
  read_timing_a: assert property (@(posedge core_clk) disable iff (reset)
    idle && rd_r && !wr_r |=> flash_req.rd ##1 state_r == fspc_pkg::ST_RDCAP ##1
    word == $past(flash_rdata))
    else $error("read timing wrong");
  timer_end_a: assert property (@(posedge core_clk) disable iff (reset)
    $fell(state_r == fspc_pkg::ST_TIME) |-> $past(timer_r) == '0)
    else $error("timed phase ended early");
  fault_set_a: assert property (@(posedge core_clk)
    reset && wr_busy && !power_on_rst |=> store_fault_flag_r)
    else $error("fault flag not set");
  bulk_unlock_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(code_readout_lock_r) |-> $past(ext_bulk) || $past(cfg_load_r))
    else $error("lock released without bulk erase");
  answer_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    pready |-> $past(idle && !rd_r && !wr_r))
    else $error("bus answered while trigger pending");

  erase_seen_c: cover property (@(posedge core_clk) disable iff (reset)
    state_r == fspc_pkg::ST_ERASE);
  program_seen_c: cover property (@(posedge core_clk) disable iff (reset)
    strm_emit && strm_idx == 4'hF);
  latch_load_c: cover property (@(posedge core_clk) disable iff (reset)
    state_r == fspc_pkg::ST_LOAD);
  ext_denied_c: cover property (@(posedge core_clk) disable iff (reset) ext_denied);
endmodule

// file: src/fspc_latch_mem.sv
// Row write latches with registered read port
`timescale 1ns/1ps
module fspc_latch_mem (
  // Clock
  input wire logic core_clk,
  // Write port
  input wire logic we,
  input wire logic [fspc_pkg::IDX_W-1:0] waddr,
  input wire logic [fspc_pkg::WORD_W-1:0] wdata,
  // Read port
  input wire logic [fspc_pkg::IDX_W-1:0] raddr,
  output logic [fspc_pkg::WORD_W-1:0] rdata
);
  logic [fspc_pkg::WORD_W-1:0] mem_r [fspc_pkg::ROW_WORDS];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata <= mem_r[raddr];
  end
endmodule

// file: src/fspc_pkg.sv
// Constants and types for the flash self-program controller
// Summary of operation
// - Data pair holds one 14-bit word; address pair holds a 15-bit location.
// - Address high byte gives upper bits, low byte gives lower bits, up to 32K.
// - Software only sets read and program triggers; hardware clears them when done.
// - Writes proceed only with store permit set; permit is clear after power-up.
// - A reset with power_on_rst low during a running write sets the store fault flag.
// - Unlock key register is write-only and reads back as zero.
// - Memory and latch writes need the unlock key sequence first.
// - Program and erase duration comes from an internal timer.
// - Readout lock at zero denies external read and write; self access unaffected.
// - Only an external bulk erase releases the readout lock, clearing everything.
// - Self-program lock blocks self write and erase over its range only.
// - Memory is organised in 16-word rows; a row is the smallest erase.
// - Sixteen 14-bit write latches, filled only through the data pair.
// - Blank words may be programmed without erasing their row first.
// - Program memory stays readable and writable during normal operation.
// - Read uses the second cycle after the trigger; data follows next cycle.
// - Row erase or program stalls the core about 2 ms, then resumes.
// - Data pair keeps a read result until another read or a software write.
package fspc_pkg;
  localparam int ADDR_W = 15;
  localparam int WORD_W = 14;
  localparam int ROW_WORDS = 16;
  localparam int IDX_W = 4;
  localparam int TIMER_W = 17;
  localparam int PROG_TIME_US = 2000;
  localparam int CLK_MHZ = 40;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_LOC_LOW = 8'h00;
  localparam logic [7:0] OFS_LOC_HIGH = 8'h04;
  localparam logic [7:0] OFS_WORD_LOW = 8'h08;
  localparam logic [7:0] OFS_WORD_HIGH = 8'h0C;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_KEY = 8'h14;
  // Control register fields
  localparam int CB_RD = 0;
  localparam int CB_WR = 1;
  localparam int CB_PERMIT = 2;
  localparam int CB_FAULT = 3;
  localparam int CB_ERASE = 4;
  localparam int CB_LATCH = 5;
  localparam int CB_CONFIG_SPACE_SELECT = 6;
  localparam int CB_BUSY = 7;
  // Unlock key bytes
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Self-program lock encodings and their protected limits
  localparam logic [1:0] WP_NONE = 2'h3;
  localparam logic [1:0] WP_QUARTER = 2'h2;
  localparam logic [1:0] WP_HALF = 2'h1;
  localparam logic [14:0] WP_LIM_QUARTER = 15'h0200;
  localparam logic [14:0] WP_LIM_HALF = 15'h0400;
  localparam logic [14:0] WP_LIM_ALL = 15'h0800;
  // External programmer commands
  localparam logic [1:0] EXT_READ = 2'h0;
  localparam logic [1:0] EXT_WRITE = 2'h1;
  localparam logic [1:0] EXT_BULK = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD = 3'h1,
    ST_RDCAP = 3'h3,
    ST_LOAD = 3'h2,
    ST_ERASE = 3'h6,
    ST_STREAM = 3'h7,
    ST_TIME = 3'h5,
    ST_FINISH = 3'h4
  } fspc_state_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic erase;
    logic bulk;
    logic cfg;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } fspc_flash_req_type;

  typedef struct packed {
    logic req;
    logic [1:0] cmd;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } fspc_ext_req_type;
endpackage
